// ==== shared/dcc_pkg.sv ====
/*
  Package for the dual comparator control block: register indices, field
  positions, reset values, modes and carrier structs.
  Assumes a 32-bit APB master and a 40 MHz pclk.
*/
package dcc_pkg;

  localparam int unsigned DCC_ADDR_W = 12;
  localparam logic [1:0] DCC_BYTE_SHIFT = 2'h2;

  // register indices; byte address is four times the index
  localparam logic [7:0] DCC_IDX_PORT_A_DATA = 8'h05;
  localparam logic [7:0] DCC_IDX_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] DCC_IDX_PERIPHERAL_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] DCC_IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] DCC_IDX_PERIPHERAL_ENABLES_TWO = 8'h8d;
  localparam logic [7:0] DCC_IDX_COMPARATOR_CONTROL = 8'h9c;
  localparam logic [7:0] DCC_IDX_COMPARATOR_REF_CONTROL = 8'h9d;

  // reset values
  localparam logic [7:0] DCC_RST_PORT_A_DATA = 8'h00;
  localparam logic [7:0] DCC_RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] DCC_RST_PERIPHERAL_FLAGS_TWO = 8'h00;
  localparam logic [7:0] DCC_RST_PORT_A_DIRECTION = 8'hff;
  localparam logic [7:0] DCC_RST_PERIPHERAL_ENABLES_TWO = 8'h00;
  localparam logic [7:0] DCC_RST_COMPARATOR_CONTROL = 8'h07;
  localparam logic [7:0] DCC_RST_COMPARATOR_REF_CONTROL = 8'h00;

  // writable bit masks, and the bits forced to one in port A direction
  localparam logic [7:0] DCC_MASK_FLAGS_TWO = 8'hd0;
  localparam logic [7:0] DCC_MASK_REF_CONTROL = 8'hef;
  localparam logic [7:0] DCC_MASK_CMP_CONTROL = 8'h3f;
  localparam logic [7:0] DCC_DIR_FORCED_ONES = 8'h20;

  // field positions
  localparam int unsigned DCC_BIT_CMP2_RESULT = 7;
  localparam int unsigned DCC_BIT_CMP1_RESULT = 6;
  localparam int unsigned DCC_BIT_CMP2_INVERT = 5;
  localparam int unsigned DCC_BIT_CMP1_INVERT = 4;
  localparam int unsigned DCC_BIT_INPUT_SWITCH = 3;
  localparam int unsigned DCC_BIT_MODE_HI = 2;
  localparam int unsigned DCC_BIT_GLOBAL_IRQ_EN = 7;
  localparam int unsigned DCC_BIT_PERIPH_IRQ_EN = 6;
  localparam int unsigned DCC_BIT_CMP_IRQ_FLAG = 6;
  localparam int unsigned DCC_BIT_CMP_IRQ_EN = 6;
  localparam int unsigned DCC_BIT_PIN_CMP1 = 3;
  localparam int unsigned DCC_BIT_PIN_CMP2 = 4;

  // comparator_mode_sel encodings
  localparam logic [2:0] DCC_MODE_RESET = 3'h0;
  localparam logic [2:0] DCC_MODE_ONE_SWITCHED = 3'h1;
  localparam logic [2:0] DCC_MODE_FOUR_SWITCHED = 3'h2;
  localparam logic [2:0] DCC_MODE_PIN_OUT = 3'h3;
  localparam logic [2:0] DCC_MODE_INDEPENDENT = 3'h4;
  localparam logic [2:0] DCC_MODE_ONE_ONLY = 3'h5;
  localparam logic [2:0] DCC_MODE_INT_REF = 3'h6;
  localparam logic [2:0] DCC_MODE_OFF = 3'h7;

  // pin indices for inverting-input selection
  localparam logic [1:0] DCC_PIN0 = 2'h0;
  localparam logic [1:0] DCC_PIN1 = 2'h1;
  localparam logic [1:0] DCC_PIN2 = 2'h2;
  localparam logic [1:0] DCC_PIN3 = 2'h3;

  localparam logic [3:0] DCC_ANALOG_ALL = 4'hf;
  localparam logic [3:0] DCC_ANALOG_NONE = 4'h0;
  localparam logic [3:0] DCC_ANALOG_PIN_OUT = 4'h7;
  localparam logic [3:0] DCC_ANALOG_ONE_ONLY = 4'h6;

  typedef struct packed {
    logic cmp1_on;
    logic cmp2_on;
    logic [1:0] cmp1_vinm_pin;
    logic [1:0] cmp2_vinm_pin;
    logic vref_to_vinp;
    logic pin_out_en;
    logic [3:0] analog_pins;
  } dcc_route_t;

  typedef struct packed {
    logic [DCC_ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } dcc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dcc_apb_rsp_t;

endpackage

// ==== core/dcc_top.sv ====
/*
  Dual comparator control: register file on APB, comparator result path,
  mismatch change detect and interrupt, pin routing for port A.
  Assumes analog comparator outputs and port pins arrive asynchronously,
  and that software observes the access-before-clear ordering.
*/
module dcc_top
  import dcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire dcc_pkg::dcc_apb_req_t apb_req,
  output dcc_pkg::dcc_apb_rsp_t apb_rsp,
  input wire logic [1:0] cmp_raw,
  input wire logic sleep_mode,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output dcc_pkg::dcc_route_t analog_route,
  output logic [7:0] ref_control,
  output logic cmp_irq,
  output logic wake_req
);
  import dcc_pkg::*;

  typedef struct packed {
    logic [7:0] port_a_latch;
    logic [7:0] interrupt_control;
    logic [7:0] peripheral_flags_two;
    logic [7:0] port_a_direction;
    logic [7:0] peripheral_enables_two;
    logic [5:0] cmp_ctl;
    logic [7:0] comparator_ref_control;
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [1:0] cmp_s3;
    logic [1:0] cmp_stable;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_stable;
    logic [1:0] result_latch;
    logic [7:0] pin_oe;
    logic [7:0] pin_drive;
    dcc_route_t route;
    logic irq;
    logic wake;
    dcc_apb_rsp_t rsp;
  } dcc_state_t;

  dcc_state_t state;
  dcc_state_t next_state;

  // fixed routing decode for every mode
  function automatic dcc_route_t mode_route(input logic [2:0] mode, input logic input_switch_sel);
    dcc_route_t r;
    r = '0;
    case (mode)
      DCC_MODE_RESET: begin
        r.analog_pins = DCC_ANALOG_ALL;
      end
      DCC_MODE_ONE_SWITCHED: begin
        r.cmp1_on = 1'b1;
        r.cmp2_on = 1'b1;
        r.cmp1_vinm_pin = input_switch_sel ? DCC_PIN3 : DCC_PIN0;
        r.cmp2_vinm_pin = DCC_PIN1;
        r.analog_pins = DCC_ANALOG_ALL;
      end
      DCC_MODE_FOUR_SWITCHED: begin
        r.cmp1_on = 1'b1;
        r.cmp2_on = 1'b1;
        r.cmp1_vinm_pin = input_switch_sel ? DCC_PIN3 : DCC_PIN0;
        r.cmp2_vinm_pin = input_switch_sel ? DCC_PIN2 : DCC_PIN1;
        r.analog_pins = DCC_ANALOG_ALL;
      end
      DCC_MODE_PIN_OUT: begin
        r.cmp1_on = 1'b1;
        r.cmp2_on = 1'b1;
        r.cmp1_vinm_pin = DCC_PIN0;
        r.cmp2_vinm_pin = DCC_PIN1;
        r.pin_out_en = 1'b1;
        r.analog_pins = DCC_ANALOG_PIN_OUT;
      end
      DCC_MODE_INDEPENDENT: begin
        r.cmp1_on = 1'b1;
        r.cmp2_on = 1'b1;
        r.cmp1_vinm_pin = DCC_PIN0;
        r.cmp2_vinm_pin = DCC_PIN1;
        r.analog_pins = DCC_ANALOG_ALL;
      end
      DCC_MODE_ONE_ONLY: begin
        r.cmp2_on = 1'b1;
        r.cmp2_vinm_pin = DCC_PIN1;
        r.analog_pins = DCC_ANALOG_ONE_ONLY;
      end
      DCC_MODE_INT_REF: begin
        r.cmp1_on = 1'b1;
        r.cmp2_on = 1'b1;
        r.cmp1_vinm_pin = DCC_PIN0;
        r.cmp2_vinm_pin = DCC_PIN1;
        r.vref_to_vinp = 1'b1;
        r.analog_pins = DCC_ANALOG_ALL;
      end
      default: begin
        r.analog_pins = DCC_ANALOG_NONE;
      end
    endcase
    return r;
  endfunction

  // read mux by register index
  function automatic logic [7:0] reg_read(input dcc_state_t s, input logic [7:0] idx, input logic [1:0] res);
    logic [7:0] v;
    v = '0;
    case (idx)
      DCC_IDX_PORT_A_DATA: v = s.pin_stable & ~{4'h0, s.route.analog_pins};
      DCC_IDX_INTERRUPT_CONTROL: v = s.interrupt_control;
      DCC_IDX_PERIPHERAL_FLAGS_TWO: v = s.peripheral_flags_two;
      DCC_IDX_PORT_A_DIRECTION: v = s.port_a_direction;
      DCC_IDX_PERIPHERAL_ENABLES_TWO: v = s.peripheral_enables_two;
      DCC_IDX_COMPARATOR_CONTROL: v = {res, s.cmp_ctl};
      DCC_IDX_COMPARATOR_REF_CONTROL: v = s.comparator_ref_control;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic idx_mapped(input logic [7:0] idx);
    return idx == DCC_IDX_PORT_A_DATA || idx == DCC_IDX_INTERRUPT_CONTROL ||
      idx == DCC_IDX_PERIPHERAL_FLAGS_TWO || idx == DCC_IDX_PORT_A_DIRECTION ||
      idx == DCC_IDX_PERIPHERAL_ENABLES_TWO || idx == DCC_IDX_COMPARATOR_CONTROL ||
      idx == DCC_IDX_COMPARATOR_REF_CONTROL;
  endfunction

  logic [1:0] cmp_invert;
  logic [1:0] cmp_result;
  logic [1:0] cmp_pin_level;
  logic [7:0] reg_idx;
  logic addr_aligned;
  logic access_phase;
  logic access_done;
  logic ctl_access;
  logic mismatch;
  logic [7:0] wdata8;

  assign cmp_invert = {state.cmp_ctl[DCC_BIT_CMP2_INVERT], state.cmp_ctl[DCC_BIT_CMP1_INVERT]};
  assign cmp_result = state.cmp_stable ^ cmp_invert;
  assign cmp_pin_level = cmp_raw ^ cmp_invert;
  assign reg_idx = apb_req.paddr[DCC_ADDR_W-1:DCC_BYTE_SHIFT] < 10'(9'h100)
    ? apb_req.paddr[DCC_BYTE_SHIFT+7:DCC_BYTE_SHIFT] : 8'h00;
  assign addr_aligned = apb_req.paddr[DCC_BYTE_SHIFT-1:0] == 2'h0
    && apb_req.paddr[DCC_ADDR_W-1:DCC_BYTE_SHIFT+8] == '0;
  assign access_phase = apb_req.psel && apb_req.penable;
  assign access_done = access_phase && state.rsp.pready;
  // any completed control access latches the outputs
  assign ctl_access = access_done && addr_aligned && reg_idx == DCC_IDX_COMPARATOR_CONTROL;
  assign mismatch = cmp_result != state.result_latch;
  assign wdata8 = apb_req.pwdata[7:0];

  always_comb begin
    logic wr;
    logic [1:0] stable_upd;
    wr = 1'b0;
    stable_upd = '0;
    next_state = state;
    // three-stage synchronizers, change counts when stages two and three agree
    next_state.cmp_s1 = cmp_raw;
    next_state.cmp_s2 = state.cmp_s1;
    next_state.cmp_s3 = state.cmp_s2;
    for (int i = 0; i < 2; i++) begin
      stable_upd[i] = state.cmp_s2[i] == state.cmp_s3[i];
      if (stable_upd[i]) begin
        next_state.cmp_stable[i] = state.cmp_s3[i];
      end
    end
    next_state.pin_s1 = port_a_in;
    next_state.pin_s2 = state.pin_s1;
    next_state.pin_s3 = state.pin_s2;
    for (int i = 0; i < 8; i++) begin
      if (state.pin_s2[i] == state.pin_s3[i]) begin
        next_state.pin_stable[i] = state.pin_s3[i];
      end
    end

    // apb: one wait state, answer one cycle into the access phase
    next_state.rsp.pready = access_phase && !state.rsp.pready;
    next_state.rsp.pslverr = 1'b0;
    next_state.rsp.prdata = '0;
    if (access_phase && !state.rsp.pready) begin
      if (!addr_aligned || !idx_mapped(reg_idx)) begin
        next_state.rsp.pslverr = 1'b1;
      end else if (!apb_req.pwrite) begin
        next_state.rsp.prdata = {24'h00_0000, reg_read(state, reg_idx, cmp_result)};
      end
    end
    wr = access_done && apb_req.pwrite && addr_aligned;
    if (wr) begin
      case (reg_idx)
        DCC_IDX_PORT_A_DATA: next_state.port_a_latch = wdata8;
        DCC_IDX_INTERRUPT_CONTROL: next_state.interrupt_control = wdata8;
        // write zero clears, write one sets; only bits 7, 6 and 4 are kept
        DCC_IDX_PERIPHERAL_FLAGS_TWO: next_state.peripheral_flags_two = wdata8 & DCC_MASK_FLAGS_TWO;
        DCC_IDX_PORT_A_DIRECTION: next_state.port_a_direction = wdata8 | DCC_DIR_FORCED_ONES;
        DCC_IDX_PERIPHERAL_ENABLES_TWO: next_state.peripheral_enables_two = wdata8 & DCC_MASK_FLAGS_TWO;
        DCC_IDX_COMPARATOR_CONTROL: next_state.cmp_ctl = wdata8[5:0] & DCC_MASK_CMP_CONTROL[5:0];
        DCC_IDX_COMPARATOR_REF_CONTROL: next_state.comparator_ref_control = wdata8 & DCC_MASK_REF_CONTROL;
        default: next_state.port_a_latch = state.port_a_latch;
      endcase
    end

    // latch current results on control access
    if (ctl_access) begin
      next_state.result_latch = cmp_result;
    end
    // set wins over a software clear in the same cycle
    if (mismatch) begin
      next_state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG] = 1'b1;
    end

    next_state.route = mode_route(next_state.cmp_ctl[DCC_BIT_MODE_HI:0],
      next_state.cmp_ctl[DCC_BIT_INPUT_SWITCH]);

    // direction bits gate the drivers, comparator or not
    next_state.pin_oe = ~next_state.port_a_direction;
    next_state.pin_drive = next_state.port_a_latch;

    next_state.irq = next_state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG]
      && next_state.peripheral_enables_two[DCC_BIT_CMP_IRQ_EN]
      && next_state.interrupt_control[DCC_BIT_PERIPH_IRQ_EN]
      && next_state.interrupt_control[DCC_BIT_GLOBAL_IRQ_EN];
    // wake needs only the comparator enable
    next_state.wake = sleep_mode
      && next_state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG]
      && next_state.peripheral_enables_two[DCC_BIT_CMP_IRQ_EN];
  end

  // reset forces the control register to mode 111
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
      state.port_a_latch <= DCC_RST_PORT_A_DATA;
      state.interrupt_control <= DCC_RST_INTERRUPT_CONTROL;
      state.peripheral_flags_two <= DCC_RST_PERIPHERAL_FLAGS_TWO;
      state.port_a_direction <= DCC_RST_PORT_A_DIRECTION;
      state.peripheral_enables_two <= DCC_RST_PERIPHERAL_ENABLES_TWO;
      state.cmp_ctl <= DCC_RST_COMPARATOR_CONTROL[5:0];
      state.comparator_ref_control <= DCC_RST_COMPARATOR_REF_CONTROL;
      state.route.analog_pins <= DCC_ANALOG_NONE;
    end else begin
      state <= next_state;
    end
  end

  // pins 3 and 4 carry comparator outputs in pin-output mode 011
  always_comb begin
    port_a_out = state.pin_drive;
    if (state.route.pin_out_en) begin
      port_a_out[DCC_BIT_PIN_CMP1] = cmp_pin_level[0];
      port_a_out[DCC_BIT_PIN_CMP2] = cmp_pin_level[1];
    end
  end
  assign port_a_oe = state.pin_oe;
  assign analog_route = state.route;
  assign ref_control = state.comparator_ref_control;
  assign cmp_irq = state.irq;
  assign wake_req = state.wake;
  assign apb_rsp = state.rsp;

  // ---- assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_result_bits;
    $rose(state.rsp.pready) && !state.rsp.pslverr && $past(reg_idx) == DCC_IDX_COMPARATOR_CONTROL
      && $past(!apb_req.pwrite) && $past(addr_aligned)
      |-> state.rsp.prdata[7:6] == $past(cmp_result);
  endproperty
  a_result_bits: assert property (p_result_bits) else $error("result bits wrong on read");

  property p_invert;
    $stable(cmp_raw) [*4]
      |-> cmp_result == (cmp_raw ^ {state.cmp_ctl[DCC_BIT_CMP2_INVERT], state.cmp_ctl[DCC_BIT_CMP1_INVERT]});
  endproperty
  a_invert: assert property (p_invert) else $error("inversion not applied");

  property p_switch;
    state.cmp_ctl[DCC_BIT_MODE_HI:0] == DCC_MODE_FOUR_SWITCHED && state.cmp_ctl[DCC_BIT_INPUT_SWITCH]
      |-> state.route.cmp1_vinm_pin == DCC_PIN3 && state.route.cmp2_vinm_pin == DCC_PIN2;
  endproperty
  a_switch: assert property (p_switch) else $error("input switch routing wrong");

  property p_int_ref;
    state.cmp_ctl[DCC_BIT_MODE_HI:0] == DCC_MODE_INT_REF |-> state.route.vref_to_vinp;
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("reference not routed in mode 110");

  property p_result_readonly;
    ctl_access && apb_req.pwrite |=> $stable(state.result_latch) || state.result_latch == $past(cmp_result);
  endproperty
  a_result_readonly: assert property (p_result_readonly) else $error("result latch corrupted");

  property p_flag_set;
    mismatch |=> state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on mismatch");

  property p_sw_clear;
    access_done && apb_req.pwrite && addr_aligned && reg_idx == DCC_IDX_PERIPHERAL_FLAGS_TWO
      && !apb_req.pwdata[DCC_BIT_CMP_IRQ_FLAG] && !mismatch |=> !state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("flag clear by zero write failed");

  property p_irq_gate;
    cmp_irq == (state.peripheral_flags_two[DCC_BIT_CMP_IRQ_FLAG] && state.peripheral_enables_two[DCC_BIT_CMP_IRQ_EN]
      && state.interrupt_control[DCC_BIT_PERIPH_IRQ_EN] && state.interrupt_control[DCC_BIT_GLOBAL_IRQ_EN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables");

  property p_latch_ends;
    ctl_access |=> state.result_latch == $past(cmp_result);
  endproperty
  a_latch_ends: assert property (p_latch_ends) else $error("access did not latch results");

  property p_oe_gate;
    ##1 port_a_oe == ~state.port_a_direction;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("pin enable not from direction");

  property p_pin_out;
    state.route.pin_out_en
      |-> port_a_out[DCC_BIT_PIN_CMP1] == (cmp_raw[0] ^ state.cmp_ctl[DCC_BIT_CMP1_INVERT])
      && port_a_out[DCC_BIT_PIN_CMP2] == (cmp_raw[1] ^ state.cmp_ctl[DCC_BIT_CMP2_INVERT]);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("comparator output not on pins");

  property p_analog_read;
    $rose(state.rsp.pready) && $past(reg_idx) == DCC_IDX_PORT_A_DATA
      && $past(!apb_req.pwrite) && $past(addr_aligned)
      |-> (state.rsp.prdata[3:0] & $past(state.route.analog_pins)) == DCC_ANALOG_NONE;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog pin read not zero");

  property p_wake;
    sleep_mode && state.peripheral_flags_two[6] && state.peripheral_enables_two[6] && $stable(sleep_mode)
      |-> ##[0:1] wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled change");

  c_mismatch_irq: cover property (mismatch ##[1:4] cmp_irq);
  c_ctl_read: cover property (ctl_access && !apb_req.pwrite);
  c_pin_mode: cover property (state.route.pin_out_en && port_a_oe[DCC_BIT_PIN_CMP1]);
  c_wake: cover property (sleep_mode ##1 wake_req);

endmodule

// ==== verif/dcc_analog_model.sv ====
/*
  Far side of the comparator block: two analog comparators and the port A pins.
  Assumes the bench sets the input levels just after rising edges.
*/
module dcc_analog_model (
  input wire logic [1:0][7:0] vinp,
  input wire logic [7:0] vinm,
  input wire logic [7:0] ext_pins,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  output logic [1:0] cmp_raw,
  output logic [7:0] port_a_in
);
  assign cmp_raw = {vinp[1] > vinm, vinp[0] > vinm};
  // device drives pin only when enabled
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_pins);
endmodule

// ==== verif/test_dual_comparator_control.sv ====
/*
  Bench for the dual comparator control block: APB tasks, read-data scoreboard.
  Assumes dcc_pkg, dcc_top and dcc_analog_model are compiled first.
*/
module test_dual_comparator_control import dcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] cc = DCC_IDX_COMPARATOR_CONTROL;
  localparam logic [7:0] fl = DCC_IDX_PERIPHERAL_FLAGS_TWO;
  localparam logic [7:0] dr = DCC_IDX_PORT_A_DIRECTION;
  logic pclk, presetn, sleep_mode, cmp_irq, wake_req;
  dcc_apb_req_t req;
  dcc_apb_rsp_t rsp;
  dcc_route_t route;
  logic [1:0] cmp_raw;
  logic [1:0][7:0] vinp;
  logic [7:0] vinm, ext_pins, port_a_in, port_a_out, port_a_oe, ref_control, r;
  logic [31:0] seed;
  logic [33:0] e;
  logic [33:0] expq[$];
  int error_cnt, total_checks;
  logic [7:0] idx_t [7] = '{DCC_IDX_PORT_A_DATA, DCC_IDX_INTERRUPT_CONTROL, fl, dr,
    DCC_IDX_PERIPHERAL_ENABLES_TWO, cc, DCC_IDX_COMPARATOR_REF_CONTROL};
  logic [7:0] rst_t [7] = '{DCC_RST_PORT_A_DATA, DCC_RST_INTERRUPT_CONTROL, DCC_RST_PERIPHERAL_FLAGS_TWO,
    DCC_RST_PORT_A_DIRECTION, DCC_RST_PERIPHERAL_ENABLES_TWO, DCC_RST_COMPARATOR_CONTROL, 8'h00};

  dcc_top i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .cmp_raw(cmp_raw),
    .sleep_mode(sleep_mode), .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .analog_route(route), .ref_control(ref_control), .cmp_irq(cmp_irq), .wake_req(wake_req));
  dcc_analog_model i_model (.vinp(vinp), .vinm(vinm), .ext_pins(ext_pins), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .cmp_raw(cmp_raw), .port_a_in(port_a_in));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (expq.size() != 0) error_cnt++;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one transfer; caller stands just after a rising edge
  task automatic apb(input logic [7:0] idx, input logic dir, input logic [7:0] wd, input logic [33:0] exp);
    seed = xs(seed);
    expq.push_back(exp);
    req.paddr <= DCC_ADDR_W'({idx, 2'b00});
    req.pwrite <= dir;
    req.pwdata <= {seed[31:8], wd};
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge pclk);
    req.penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d, {2'b10, 32'h0});
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b0, 8'h00, {2'b10, 24'h0, d});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic set_raw(input logic [1:0] v);
    vinp[0] <= v[0] ? 8'h80 : 8'h40;
    vinp[1] <= v[1] ? 8'h80 : 8'h40;
  endtask

  // scoreboard: oldest note against each answer
  always @(negedge pclk) begin
    if (rsp.pready === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[33]) check("prdata", rsp.prdata, e[31:0]);
      check("pslverr", 32'(rsp.pslverr), 32'(e[32]));
    end
  end

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #100us;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    sleep_mode = 1'b0;
    ext_pins = 8'h00;
    vinm = 8'h60;
    vinp = '0;
    seed = 32'h488a;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("route", 32'(route), 32'h0);
    for (int i = 0; i < 7; i++) rd(idx_t[i], rst_t[i]);
    apb(8'h10, 1'b0, 8'h00, {2'b11, 32'h0});
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      set_raw(m[1:0]);
      wr(cc, {2'b11, m[3:2], 1'b0, DCC_MODE_INDEPENDENT});
      tick(5);
      rd(cc, {m[1:0] ^ m[3:2], m[3:2], 1'b0, DCC_MODE_INDEPENDENT});
    end
    $display("test result done");
    set_raw(2'b00);
    for (int m = 0; m < 8; m++) begin
      wr(cc, 8'(m));
      tick(5);
      rd(cc, 8'(m));
      if (m == 6) check("vref", 32'(route.vref_to_vinp), 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
      wr(cc, {4'h0, k[0], 1'b0, k[1], ~k[1]});
      tick(2);
      check("vinm1", 32'(route.cmp1_vinm_pin), 32'(k[0] ? DCC_PIN3 : DCC_PIN0));
      if (k >= 2) check("vinm2", 32'(route.cmp2_vinm_pin), 32'(k[0] ? DCC_PIN2 : DCC_PIN1));
    end
    $display("test routing done");
    ext_pins <= 8'hff;
    wr(cc, {5'h0, DCC_MODE_RESET});
    rd(DCC_IDX_PORT_A_DATA, ~{4'h0, DCC_ANALOG_ALL});
    wr(cc, {5'h0, DCC_MODE_OFF});
    rd(DCC_IDX_PORT_A_DATA, 8'hff);
    seed = xs(seed);
    r = seed[7:0];
    wr(DCC_IDX_COMPARATOR_REF_CONTROL, r);
    rd(DCC_IDX_COMPARATOR_REF_CONTROL, r & DCC_MASK_REF_CONTROL);
    check("ref_control", 32'(ref_control), 32'(r & DCC_MASK_REF_CONTROL));
    $display("test port done");
    wr(dr, 8'he7);
    wr(cc, {4'h3, 1'b0, DCC_MODE_PIN_OUT});
    set_raw(2'b01);
    tick(3);
    check("oe", 32'(port_a_oe), 32'h18);
    check("pins", 32'(port_a_out[4:3]), 32'h2);
    set_raw(2'b10);
    tick(1);
    check("pins", 32'(port_a_out[4:3]), 32'h1);
    wr(dr, 8'hff);
    tick(1);
    check("oe", 32'(port_a_oe), 32'h0);
    $display("test pin output done");
    set_raw(2'b00);
    wr(cc, {5'h0, DCC_MODE_INDEPENDENT});
    wr(DCC_IDX_INTERRUPT_CONTROL, 8'hc0);
    wr(DCC_IDX_PERIPHERAL_ENABLES_TWO, 8'h40);
    tick(5);
    rd(cc, 8'h04);
    wr(fl, 8'h00);
    rd(fl, 8'h00);
    check("irq", 32'(cmp_irq), 32'h0);
    set_raw(2'b01);
    tick(6);
    check("irq", 32'(cmp_irq), 32'h1);
    wr(fl, 8'h00);
    rd(fl, 8'h40);
    rd(cc, 8'h44);
    wr(fl, 8'h00);
    rd(fl, 8'h00);
    check("irq", 32'(cmp_irq), 32'h0);
    wr(fl, 8'h40);
    rd(fl, 8'h40);
    wr(DCC_IDX_INTERRUPT_CONTROL, 8'h40);
    tick(2);
    check("irq", 32'(cmp_irq), 32'h0);
    rd(fl, 8'h40);
    sleep_mode <= 1'b1;
    tick(3);
    check("wake", 32'(wake_req), 32'h1);
    rd(cc, 8'h44);
    sleep_mode <= 1'b0;
    $display("test interrupt done");
    tick(3);
    set_raw(2'b00);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(cc, DCC_RST_COMPARATOR_CONTROL);
    rd(fl, DCC_RST_PERIPHERAL_FLAGS_TWO);
    check("wake", 32'(wake_req), 32'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
